// ==== rtl/woor_opts_regs.vh ====
// Constants for the write-once system option registers
// Contract
// [RL1] Each option register takes one write after every reset, then holds it.
// [RL2] Reset clears every option bit except the supply mode bit.
// [RL3] Option registers read back latched values at any time.
// [RL4] The three registers decode at addresses 0009, 001E and 001F.
// [RL5] Software should make its single write right after reset.
// [RL6] Watchdog rate bit: 1 gives 8176 cycles, 0 gives 262128 cycles.
// [RL7] With power on, run-in-stop bit keeps the voltage monitor alive in stop.
// [RL8] Reset-disable bit set blocks voltage monitor resets; clear lets them pass.
// [RL9] Power-disable bit set turns the voltage monitor fully off; code still passes its resets to o_uv_reset.
// [RL10] Supply mode bit: 1 is 5 V, 0 is 3 V; only power-on reset clears it.
// [RL11] Short wake bit: 32 cycles stop-exit delay when 1, 4096 when 0.
// [RL12] Leaving stop by a voltage monitor reset always uses the long delay.
// [RL13] Software keeps short wake clear when the oscillator stops in stop mode.
// [RL14] Stop enable bit set lets stop run; clear makes it an illegal opcode.
// [RL15] Watchdog disable bit set stops the watchdog; clear lets it run.
// [RL16] Baud source bit: 1 is bus clock, 0 is crystal clock.
// [RL17] Crystal enable acts only while external clock enable is also set.
// [RL18] Crystal enable set makes the second oscillator pin a crystal pin.
// [RL19] Crystal enable selects crystal ranges, else external clock range.
// [RL20] Stabilisation divider times out after 4096 cycles with crystal, else 16.
// [RL21] External clock enable makes the first oscillator pin a clock input.
// [RL22] Oscillator run-in-stop keeps clocks running; clear forces both low.
// [RL23] Each register tracks its own write lock until any reset re-arms it.
// [RL24] The supply mode bit lives in storage cleared only by power-on reset.
`ifndef WOOR_OPTS_REGS_VH
`define WOOR_OPTS_REGS_VH

`define WOOR_ADDR_OPT1 16'h001f
`define WOOR_ADDR_OPT2 16'h001e
`define WOOR_ADDR_OPT3 16'h0009

`define WOOR_RST_BYTE 8'h00
`define WOOR_RD_UNMAPPED 8'h00

// Option register 1 fields
`define WOOR_B1_WDT_RATE 7
`define WOOR_B1_UV_RUN_STOP 6
`define WOOR_B1_UV_RST_DIS 5
`define WOOR_B1_UV_PWR_DIS 4
`define WOOR_B1_UV_SUPPLY 3
`define WOOR_B1_SHORT_WAKE 2
`define WOOR_B1_STOP_EN 1
`define WOOR_B1_WDT_DIS 0

// Option register 2 fields
`define WOOR_B2_BAUD_SRC 0
`define WOOR_B2_XTAL_EN 1
`define WOOR_B2_EXTCLK_EN 2
`define WOOR_B2_OSC_RUN_STOP 3

// Counts in crystal-clock cycles
`define WOOR_WDT_SHORT 19'd8176
`define WOOR_WDT_LONG 19'd262128
`define WOOR_WAKE_SHORT 13'd32
`define WOOR_WAKE_LONG 13'd4096
`define WOOR_STAB_XTAL 13'd4096
`define WOOR_STAB_EXT 13'd16

`endif

// ==== rtl/woor_opts.v ====
// Write-once system option registers and the option outputs they drive
`include "woor_opts_regs.vh"

module woor_opts #(
    parameter [18:0] WDT_SHORT_CYCLES = `WOOR_WDT_SHORT,
    parameter [18:0] WDT_LONG_CYCLES = `WOOR_WDT_LONG,
    parameter [12:0] WAKE_SHORT_CYCLES = `WOOR_WAKE_SHORT,
    parameter [12:0] WAKE_LONG_CYCLES = `WOOR_WAKE_LONG,
    parameter [12:0] STAB_XTAL_CYCLES = `WOOR_STAB_XTAL,
    parameter [12:0] STAB_EXT_CYCLES = `WOOR_STAB_EXT
) (
    input wire i_clk_sys,
    input wire i_rst_n,
    input wire i_por_n,
    input wire [15:0] i_addr,
    input wire [7:0] i_wdata,
    input wire i_wr,
    input wire i_rd,
    output reg [7:0] o_rdata,
    input wire i_stop_mode,
    input wire i_wake_by_uv_reset,
    input wire i_uv_reset_req,
    output reg [18:0] o_wdt_timeout_cycles,
    output reg o_wdt_enable,
    output reg o_uv_powered,
    output reg o_uv_active,
    output reg o_uv_reset,
    output reg o_uv_supply_5v,
    output reg [12:0] o_wake_delay_cycles,
    output reg o_stop_enable,
    output reg o_baud_from_bus,
    output reg o_osc_in_is_clock,
    output reg o_osc_out_is_crystal,
    output reg o_monitor_crystal_range,
    output reg [12:0] o_stab_cycles,
    output reg o_clocks_run,
    output reg [7:0] o_opt3
);

    // Any reset re-arms the locks; power-on reset is one of them
    wire any_rst = ~i_rst_n | ~i_por_n;

    reg [7:0] opt1_q;
    reg [7:0] opt2_q;
    reg [7:0] opt3_q;
    reg supply_q;
    reg lock1_q;
    reg lock2_q;
    reg lock3_q;
    reg uv_req_m_q;
    reg uv_req_s_q;

    wire sel1 = (i_addr == `WOOR_ADDR_OPT1); // RL4
    wire sel2 = (i_addr == `WOOR_ADDR_OPT2); // RL4
    wire sel3 = (i_addr == `WOOR_ADDR_OPT3); // RL4

    wire wr1 = i_wr & sel1 & ~lock1_q; // RL1
    wire wr2 = i_wr & sel2 & ~lock2_q; // RL1
    wire wr3 = i_wr & sel3 & ~lock3_q; // RL1

    // Supply bit is excluded so general resets cannot disturb it
    always @(posedge i_clk_sys) begin
        if (any_rst) begin
            opt1_q <= `WOOR_RST_BYTE; // RL2
            opt2_q <= `WOOR_RST_BYTE; // RL2
            opt3_q <= `WOOR_RST_BYTE; // RL2
            lock1_q <= 1'b0; // RL23
            lock2_q <= 1'b0; // RL23
            lock3_q <= 1'b0; // RL23
        end else begin
            if (wr1) begin
                opt1_q <= i_wdata; // RL1
                lock1_q <= 1'b1; // RL23
            end
            if (wr2) begin
                opt2_q <= i_wdata; // RL1
                lock2_q <= 1'b1; // RL23
            end
            if (wr3) begin
                opt3_q <= i_wdata; // RL1
                lock3_q <= 1'b1; // RL23
            end
        end
    end

    always @(posedge i_clk_sys) begin
        if (!i_por_n) begin
            supply_q <= 1'b0; // RL24
        end else if (wr1 && i_rst_n) begin
            supply_q <= i_wdata[`WOOR_B1_UV_SUPPLY]; // RL10
        end
    end

    // Read port; supply bit merged from its own storage
    always @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            o_rdata <= `WOOR_RD_UNMAPPED;
        end else if (i_rd) begin
            if (sel1) begin
                o_rdata <= {opt1_q[7:4], supply_q, opt1_q[2:0]}; // RL3
            end else if (sel2) begin
                o_rdata <= opt2_q; // RL3
            end else if (sel3) begin
                o_rdata <= opt3_q; // RL3
            end else begin
                o_rdata <= `WOOR_RD_UNMAPPED;
            end
        end else begin
            o_rdata <= `WOOR_RD_UNMAPPED;
        end
    end

    // Monitor reset request comes from an analog block on no clock
    always @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            uv_req_m_q <= 1'b0;
            uv_req_s_q <= 1'b0;
        end else begin
            uv_req_m_q <= i_uv_reset_req;
            uv_req_s_q <= uv_req_m_q;
        end
    end

    wire pwr_dis = opt1_q[`WOOR_B1_UV_PWR_DIS];
    wire ext_en = opt2_q[`WOOR_B2_EXTCLK_EN];
    // Crystal bit is ignored without the external clock enable
    wire xtal_eff = ext_en & opt2_q[`WOOR_B2_XTAL_EN]; // RL17
    // Short wake alone is risky if the oscillator halts in stop
    wire short_ok = opt1_q[`WOOR_B1_SHORT_WAKE] & ~i_wake_by_uv_reset; // RL12

    // Derived option outputs, registered one cycle behind the options
    always @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            o_wdt_timeout_cycles <= WDT_LONG_CYCLES;
            o_wdt_enable <= 1'b0;
            o_uv_powered <= 1'b0;
            o_uv_active <= 1'b0;
            o_uv_reset <= 1'b0;
            o_uv_supply_5v <= 1'b0;
            o_wake_delay_cycles <= WAKE_LONG_CYCLES;
            o_stop_enable <= 1'b0;
            o_baud_from_bus <= 1'b0;
            o_osc_in_is_clock <= 1'b0;
            o_osc_out_is_crystal <= 1'b0;
            o_monitor_crystal_range <= 1'b0;
            o_stab_cycles <= STAB_EXT_CYCLES;
            o_clocks_run <= 1'b0;
            o_opt3 <= `WOOR_RST_BYTE;
        end else begin
            o_wdt_timeout_cycles <= opt1_q[`WOOR_B1_WDT_RATE] ?
                WDT_SHORT_CYCLES : WDT_LONG_CYCLES; // RL6
            o_wdt_enable <= ~opt1_q[`WOOR_B1_WDT_DIS]; // RL15
            o_uv_powered <= ~pwr_dis; // RL9
            o_uv_active <= ~pwr_dis &
                (~i_stop_mode | opt1_q[`WOOR_B1_UV_RUN_STOP]); // RL7
            o_uv_reset <= uv_req_s_q & ~opt1_q[`WOOR_B1_UV_RST_DIS]; // RL8
            o_uv_supply_5v <= supply_q; // RL10
            o_wake_delay_cycles <= short_ok ?
                WAKE_SHORT_CYCLES : WAKE_LONG_CYCLES; // RL11
            o_stop_enable <= opt1_q[`WOOR_B1_STOP_EN]; // RL14
            o_baud_from_bus <= opt2_q[`WOOR_B2_BAUD_SRC]; // RL16
            o_osc_in_is_clock <= ext_en; // RL21
            o_osc_out_is_crystal <= xtal_eff; // RL18
            o_monitor_crystal_range <= xtal_eff; // RL19
            o_stab_cycles <= xtal_eff ? STAB_XTAL_CYCLES : STAB_EXT_CYCLES; // RL20
            o_clocks_run <= ~i_stop_mode | opt2_q[`WOOR_B2_OSC_RUN_STOP]; // RL22
            o_opt3 <= opt3_q;
        end
    end

endmodule // woor_opts

// ==== tb/woor_opts_props.sv ====
// Concurrent checks on the option register ports
`include "woor_opts_regs.vh"
module woor_opts_props #(
    parameter [18:0] WDT_SHORT_CYCLES = `WOOR_WDT_SHORT,
    parameter [18:0] WDT_LONG_CYCLES = `WOOR_WDT_LONG,
    parameter [12:0] WAKE_LONG_CYCLES = `WOOR_WAKE_LONG,
    parameter [12:0] STAB_XTAL_CYCLES = `WOOR_STAB_XTAL,
    parameter [12:0] STAB_EXT_CYCLES = `WOOR_STAB_EXT
) (
    input wire i_clk_sys,
    input wire i_rst_n,
    input wire i_por_n,
    input wire [15:0] i_addr,
    input wire i_rd,
    input wire [7:0] o_rdata,
    input wire i_stop_mode,
    input wire i_wake_by_uv_reset,
    input wire i_uv_reset_req,
    input wire [18:0] o_wdt_timeout_cycles,
    input wire o_uv_powered,
    input wire o_uv_active,
    input wire o_uv_reset,
    input wire [12:0] o_wake_delay_cycles,
    input wire o_osc_in_is_clock,
    input wire o_osc_out_is_crystal,
    input wire o_monitor_crystal_range,
    input wire [12:0] o_stab_cycles,
    input wire o_clocks_run
);
    default clocking cb @(posedge i_clk_sys); endclocking
    // Either reset clears the registers, so both silence the checks
    default disable iff (!i_rst_n || !i_por_n);
    chk_rd_unmapped: assert property (i_rd && i_addr != `WOOR_ADDR_OPT1 &&
        i_addr != `WOOR_ADDR_OPT2 && i_addr != `WOOR_ADDR_OPT3 |=> o_rdata == 8'h00)
        else $error("unmapped read returned data");
    chk_wdt_rate: assert property (o_wdt_timeout_cycles == WDT_SHORT_CYCLES ||
        o_wdt_timeout_cycles == WDT_LONG_CYCLES) else $error("bad watchdog timeout");
    chk_uv_off: assert property (!o_uv_powered |-> !o_uv_active)
        else $error("monitor active while unpowered");
    chk_wake_long: assert property (i_wake_by_uv_reset |=>
        o_wake_delay_cycles == WAKE_LONG_CYCLES) else $error("short wake after monitor reset");
    chk_clocks_run: assert property (!i_stop_mode |=> o_clocks_run)
        else $error("clocks halted outside stop");
    chk_xtal_gate: assert property (o_osc_out_is_crystal |-> o_osc_in_is_clock)
        else $error("crystal pin without external clock");
    chk_xtal_range: assert property (o_monitor_crystal_range == o_osc_out_is_crystal)
        else $error("monitor range mismatch");
    chk_stab_div: assert property (o_stab_cycles ==
        (o_osc_out_is_crystal ? STAB_XTAL_CYCLES : STAB_EXT_CYCLES)) else $error("bad divider");
    chk_uv_sync: assert property (o_uv_reset |-> $past(i_uv_reset_req, 3))
        else $error("monitor reset without request");
endmodule // woor_opts_props
bind woor_opts woor_opts_props #(.WDT_SHORT_CYCLES(WDT_SHORT_CYCLES),
    .WDT_LONG_CYCLES(WDT_LONG_CYCLES), .WAKE_LONG_CYCLES(WAKE_LONG_CYCLES),
    .STAB_XTAL_CYCLES(STAB_XTAL_CYCLES), .STAB_EXT_CYCLES(STAB_EXT_CYCLES)) u_props (.*);

// ==== tb/tb_top.sv ====
// Self-checking bench for the write-once option registers
`include "woor_opts_regs.vh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic i_clk_sys = 0, i_rst_n = 0, i_por_n = 0, i_wr = 0, i_rd = 0;
    logic i_stop_mode = 0, i_wake_by_uv_reset = 0, i_uv_reset_req = 0;
    logic [15:0] i_addr = 16'h0000;
    logic [7:0] i_wdata = 8'h00;
    wire [7:0] o_rdata, o_opt3;
    wire [18:0] o_wdt_timeout_cycles;
    wire [12:0] o_wake_delay_cycles, o_stab_cycles;
    wire o_wdt_enable, o_uv_powered, o_uv_active, o_uv_reset, o_uv_supply_5v, o_stop_enable;
    wire o_baud_from_bus, o_osc_in_is_clock, o_osc_out_is_crystal, o_monitor_crystal_range;
    wire o_clocks_run;
    int mismatches = 0, checks = 0;
    always #50 i_clk_sys = ~i_clk_sys;
    woor_opts dut (.*);
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        checks++;
        if (s !== e) begin
            mismatches++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge i_clk_sys);
        i_wr <= 1'b1; i_addr <= a; i_wdata <= d;
    endtask
    // Read data stands for one cycle only, so it is sampled right there
    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        @(posedge i_clk_sys);
        i_wr <= 1'b0; i_rd <= 1'b1; i_addr <= a;
        @(posedge i_clk_sys);
        i_rd <= 1'b0;
        #1 chk(o_rdata, e);
    endtask
    task automatic idle(input int n);
        @(posedge i_clk_sys);
        i_wr <= 1'b0; i_rd <= 1'b0;
        repeat (n) @(posedge i_clk_sys);
        #1;
    endtask
    task automatic rst(input logic por);
        @(posedge i_clk_sys);
        i_rst_n <= 1'b0; if (por) i_por_n <= 1'b0;
        repeat (5) @(posedge i_clk_sys);
        i_rst_n <= 1'b1; i_por_n <= 1'b1;
    endtask
    task automatic close_out;
        if (mismatches == 0 && checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        rst(1'b1);
        rd(`WOOR_ADDR_OPT1, 8'h00);
        rd(`WOOR_ADDR_OPT2, 8'h00);
        idle(1);
        chk(o_wdt_timeout_cycles, `WOOR_WDT_LONG);
        chk(o_wdt_enable, 1);
        chk(o_stab_cycles, `WOOR_STAB_EXT);
        chk(o_uv_powered, 1);
        // Options written once the reset defaults have been read back and checked
        wr(`WOOR_ADDR_OPT1, 8'hae); wr(`WOOR_ADDR_OPT2, 8'h53); wr(`WOOR_ADDR_OPT3, 8'h5a);
        wr(`WOOR_ADDR_OPT1, 8'h00); wr(`WOOR_ADDR_OPT2, 8'h00); wr(`WOOR_ADDR_OPT3, 8'h00);
        rd(`WOOR_ADDR_OPT1, 8'hae);
        rd(`WOOR_ADDR_OPT2, 8'h53);
        rd(`WOOR_ADDR_OPT3, 8'h5a);
        chk(o_opt3, 8'h5a);
        rd(16'h0010, 8'h00);
        @(posedge i_clk_sys);
        i_uv_reset_req <= 1'b1; i_stop_mode <= 1'b1;
        idle(4);
        chk(o_wdt_timeout_cycles, `WOOR_WDT_SHORT);
        chk(o_uv_supply_5v, 1);
        chk(o_wake_delay_cycles, `WOOR_WAKE_SHORT);
        chk(o_stop_enable, 1);
        chk(o_baud_from_bus, 1);
        chk(o_osc_out_is_crystal, 0);
        chk(o_uv_reset, 0);
        chk(o_uv_active, 0);
        chk(o_clocks_run, 0);
        @(posedge i_clk_sys);
        i_wake_by_uv_reset <= 1'b1;
        idle(2);
        chk(o_wake_delay_cycles, `WOOR_WAKE_LONG);
        // A plain reset must keep the supply mode bit
        rst(1'b0);
        rd(`WOOR_ADDR_OPT1, 8'h08);
        // Short wake left clear while the crystal setup is chosen
        wr(`WOOR_ADDR_OPT1, 8'h49); wr(`WOOR_ADDR_OPT2, 8'h0e);
        idle(4);
        chk(o_wdt_enable, 0);
        chk(o_uv_active, 1);
        chk(o_uv_reset, 1);
        chk(o_clocks_run, 1);
        chk(o_osc_in_is_clock, 1);
        chk(o_osc_out_is_crystal, 1);
        chk(o_monitor_crystal_range, 1);
        chk(o_stab_cycles, `WOOR_STAB_XTAL);
        chk(o_wake_delay_cycles, `WOOR_WAKE_LONG);
        rst(1'b1);
        rd(`WOOR_ADDR_OPT1, 8'h00);
        wr(`WOOR_ADDR_OPT1, 8'h10);
        idle(3);
        chk(o_uv_powered, 0);
        close_out;
    end
    initial begin
        repeat (2000) @(posedge i_clk_sys);
        mismatches++;
        close_out;
    end
endmodule // tb_top
